// ### design/ccpt_pkg.sv
// Package for the capture/compare/PWM timer: register offsets, field positions,
// reset values, clock-select codes and the packed structs shared by the design.
// Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
`default_nettype none

package ccpt_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CCPT_OFS_COUNT   = 8'h00;  // free_run_count
  localparam logic [7:0] CCPT_OFS_GRA     = 8'h04;  // general_reg_a
  localparam logic [7:0] CCPT_OFS_GRB     = 8'h08;  // general_reg_b
  localparam logic [7:0] CCPT_OFS_GRC     = 8'h0C;  // general_reg_c
  localparam logic [7:0] CCPT_OFS_GRD     = 8'h10;  // general_reg_d
  localparam logic [7:0] CCPT_OFS_MODE    = 8'h14;  // timer_mode_reg
  localparam logic [7:0] CCPT_OFS_CTRL    = 8'h18;  // timer_control_reg
  localparam logic [7:0] CCPT_OFS_IRQEN   = 8'h1C;  // timer_irq_enable_reg
  localparam logic [7:0] CCPT_OFS_STATUS  = 8'h20;  // timer_status_reg
  localparam logic [7:0] CCPT_OFS_IOAB    = 8'h24;  // io_control_ab
  localparam logic [7:0] CCPT_OFS_IOCD    = 8'h28;  // io_control_cd
  localparam int         CCPT_ADDR_W      = 8;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  // Mode: [0] counter start, [1] buffer A, [2] buffer B, [5:3] PWM on B,C,D
  localparam int CCPT_MODE_START = 0;
  localparam int CCPT_MODE_BUFA  = 1;
  localparam int CCPT_MODE_BUFB  = 2;
  localparam int CCPT_MODE_PWM   = 3;
  // Control: [3:0] initial levels A..D, [6:4] clock select, [7] clear on A
  localparam int CCPT_CTRL_LVL   = 0;
  localparam int CCPT_CTRL_CKS   = 4;
  localparam int CCPT_CTRL_CLEAR_ON_MATCH_A  = 7;
  // Irq enable: [3:0] match A..D, [7] overflow. Status same layout.
  localparam int CCPT_FLG_OVF    = 7;
  // I/O control: per channel 3 bits {capture, sel1, sel0} at 0 and 4
  localparam int CCPT_IO_STRIDE  = 4;
  localparam int CCPT_IO_CAP     = 2;

  localparam logic [15:0] CCPT_COUNT_RST = 16'h0000;
  localparam logic [15:0] CCPT_GR_RST    = 16'hFFFF;
  localparam logic [15:0] CCPT_COUNT_MAX = 16'hFFFF;

  // Output selection in compare mode
  localparam logic [1:0] CCPT_OUT_NONE = 2'h0;
  localparam logic [1:0] CCPT_OUT_LOW  = 2'h1;
  localparam logic [1:0] CCPT_OUT_HIGH = 2'h2;
  localparam logic [1:0] CCPT_OUT_TOG  = 2'h3;
  // Edge selection in capture mode
  localparam logic [1:0] CCPT_EDGE_RISE = 2'h0;
  localparam logic [1:0] CCPT_EDGE_FALL = 2'h1;

  // Clock-select codes: system clock divided by 1,2,4,8,16,32,64, or external
  localparam logic [2:0] CCPT_CKS_EXT   = 3'h7;
  localparam int         CCPT_PRESC_W   = 6;

  // AHB encodings
  localparam logic [1:0] CCPT_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] CCPT_HSIZE_WORD    = 3'h2;

  // One channel's I/O control field
  typedef struct packed {
    logic       capture;
    logic [1:0] sel;
  } ccpt_io_t;

  // Timer pin outputs: drive level and active-low enable
  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe_n;
  } ccpt_pins_t;

endpackage : ccpt_pkg

`default_nettype wire

// ### design/ccpt_timer.sv
// Capture/compare/PWM timer with a 16-bit counter and four general registers,
// reached as a single AHB-Lite slave. Timer pins are split into in/out/enable.
// Assumes one system clock, single word transfers, and asynchronous pin inputs.
//
// How it works
// - Sixteen-bit read/write up-counter, clock chosen by three-bit select field.
// - Clear-on-match with A in compare clears counter, sets A flag, restarts.
// - Rollover from all ones sets overflow flag; interrupt if enabled.
// - Reset loads counter with zero.
// - Each general register is compare or capture, chosen by I/O control.
// - Compare registers match counter continuously; flag and interrupt on match.
// - Capture registers store counter on selected pin edge; flag and interrupt.
// - Buffer bits make C and D buffers for A and B.
// - Buffered compare A copies C into A at every match A.
// - Buffered capture A moves old A into C, counter into A.
// - General registers reset to all ones; accessed as whole words.
// - Counter stopped after reset, counts only while start bit set.
// - Compare match drives pin low, high or toggles; same level unchanged.
// - Capture on rising, falling or both pin edges as selected.
// - PWM: A sets period, B,C,D duties, all act as compares.
// - PWM level bit 1: high at match A, low at duty; 0 inverts.
// - PWM duty equal to period leaves pin unchanged at match.
// - PWM with B buffered copies D into B at every match B.
// - Match fires in last cycle of equality as counter advances.
// - Output select: 00 none, 01 low, 10 high, 11 toggle.
// - Edge select: 00 rising, 01 falling, 1X both edges.
// - Set flag clears only after read as one then written zero.
`default_nettype none

module ccpt_timer
  import ccpt_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_n_i,
  // AHB-Lite slave
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  // Timer pins A..D and external count clock
  input  wire logic [3:0]       timer_pin_i,
  output logic      [3:0]       timer_pin_o,
  output logic      [3:0]       timer_pin_oe_n_o,
  input  wire logic             ext_clk_i,
  output logic                  irq_o
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] free_run_count;
  logic [CNT_W-1:0] gr [4];
  logic [7:0]       timer_mode_reg;
  logic [7:0]       timer_control_reg;
  logic [7:0]       timer_irq_enable_reg;
  logic [7:0]       timer_status_reg;
  logic [7:0]       io_control_ab;
  logic [7:0]       io_control_cd;
  logic [3:0]       pin_level;
  ccpt_io_t         io_cfg [4];
  ccpt_pins_t       pins;

  assign io_cfg[0] = io_control_ab[2:0];
  assign io_cfg[1] = io_control_ab[CCPT_IO_STRIDE +: 3];
  assign io_cfg[2] = io_control_cd[2:0];
  assign io_cfg[3] = io_control_cd[CCPT_IO_STRIDE +: 3];

  // ----------------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------------
  logic                   ph_wr;
  logic                   ph_rd;
  logic [CCPT_ADDR_W-1:0] ph_addr;
  logic                   take;

  assign take = hsel_i && hready_i && (htrans_i == CCPT_HTRANS_NONSEQ);

  // Only whole-word writes are decoded; narrower write sizes are ignored
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= '0;
    end else begin
      ph_wr   <= take && hwrite_i && (hsize_i == CCPT_HSIZE_WORD);
      ph_rd   <= take && !hwrite_i;
      ph_addr <= haddr_i[CCPT_ADDR_W-1:0];
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  logic wr_count;
  logic wr_mode;
  logic wr_ctrl;
  logic wr_irqen;
  logic wr_status;
  logic wr_ab;
  logic wr_cd;
  logic [3:0] wr_gr;

  assign wr_count  = ph_wr && (ph_addr == CCPT_OFS_COUNT);
  assign wr_mode   = ph_wr && (ph_addr == CCPT_OFS_MODE);
  assign wr_ctrl   = ph_wr && (ph_addr == CCPT_OFS_CTRL);
  assign wr_irqen  = ph_wr && (ph_addr == CCPT_OFS_IRQEN);
  assign wr_status = ph_wr && (ph_addr == CCPT_OFS_STATUS);
  assign wr_ab     = ph_wr && (ph_addr == CCPT_OFS_IOAB);
  assign wr_cd     = ph_wr && (ph_addr == CCPT_OFS_IOCD);
  assign wr_gr[0]  = ph_wr && (ph_addr == CCPT_OFS_GRA);
  assign wr_gr[1]  = ph_wr && (ph_addr == CCPT_OFS_GRB);
  assign wr_gr[2]  = ph_wr && (ph_addr == CCPT_OFS_GRC);
  assign wr_gr[3]  = ph_wr && (ph_addr == CCPT_OFS_GRD);

  // ----------------------------------------------------------------------
  // Pin synchronisers: three stages, change once stages two and three agree
  // ----------------------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] stable;
  logic [4:0] stable_d;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1    <= '0;
      sync2    <= '0;
      sync3    <= '0;
      stable   <= '0;
      stable_d <= '0;
    end else begin
      sync1    <= {ext_clk_i, timer_pin_i};
      sync2    <= sync1;
      sync3    <= sync2;
      for (int i = 0; i < 5; i++) begin
        if (sync2[i] == sync3[i]) begin
          stable[i] <= sync3[i];
        end
      end
      stable_d <= stable;
    end
  end

  logic [3:0] rise;
  logic [3:0] fall;
  logic       ext_rise;
  assign rise     = stable[3:0] & ~stable_d[3:0];
  assign fall     = ~stable[3:0] & stable_d[3:0];
  // Two-cycle minimum width keeps a pulse through the agree filter
  assign ext_rise = stable[4] & ~stable_d[4];

  // ----------------------------------------------------------------------
  // Count clock: prescaler taps or external edge
  // ----------------------------------------------------------------------
  logic [CCPT_PRESC_W-1:0] presc;
  logic [2:0]              cks;
  logic                    tick;

  assign cks = timer_control_reg[CCPT_CTRL_CKS +: 3];

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  // A tick is one cycle per divided period; divide-by-one ticks every cycle
  always_comb begin
    if (cks == CCPT_CKS_EXT) begin
      tick = ext_rise;
    end else if (cks == 3'h0) begin
      tick = 1'b1;
    end else begin
      tick = (presc[cks-3'h1 -: 1] == 1'b1) &&
             (presc & ((CCPT_PRESC_W'(1) << cks) - 1'b1)) ==
             (CCPT_PRESC_W'(1) << (cks - 3'h1));
    end
  end

  logic adv;
  assign adv = tick && timer_mode_reg[CCPT_MODE_START];

  // ----------------------------------------------------------------------
  // Compare and capture events
  // ----------------------------------------------------------------------
  logic [3:0] pwm_on;
  logic [3:0] is_cmp;
  logic [3:0] cmp_hit;
  logic [3:0] cap_hit;
  logic       any_pwm;

  assign pwm_on  = {timer_mode_reg[CCPT_MODE_PWM +: 3], 1'b0};
  assign any_pwm = |pwm_on;

  // Match fires as the counter leaves the equal value
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_evt
      assign is_cmp[g]  = !io_cfg[g].capture || pwm_on[g] ||
                          ((g == 0) && any_pwm);
      assign cmp_hit[g] = is_cmp[g] && adv && (free_run_count == gr[g]);
      assign cap_hit[g] = !is_cmp[g] &&
                          ((io_cfg[g].sel[1]) ? (rise[g] | fall[g]) :
                           (io_cfg[g].sel == CCPT_EDGE_FALL) ? fall[g] :
                           rise[g]);
    end
  endgenerate

  logic clr_a;
  assign clr_a = cmp_hit[0] && (timer_control_reg[CCPT_CTRL_CLEAR_ON_MATCH_A] || any_pwm);

  // ----------------------------------------------------------------------
  // Counter: clear beats write, write beats count
  // ----------------------------------------------------------------------
  logic ovf_evt;
  assign ovf_evt = adv && !clr_a && (free_run_count == CCPT_COUNT_MAX);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      free_run_count <= CCPT_COUNT_RST;
    end else if (clr_a) begin
      free_run_count <= CCPT_COUNT_RST;
    end else if (wr_count) begin
      free_run_count <= hwdata_i[CNT_W-1:0];
    end else if (adv) begin
      free_run_count <= free_run_count + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // General registers with buffering: C feeds A, D feeds B
  // ----------------------------------------------------------------------
  logic buf_a;
  logic buf_b;
  assign buf_a = timer_mode_reg[CCPT_MODE_BUFA];
  assign buf_b = timer_mode_reg[CCPT_MODE_BUFB];

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 4; i++) begin
        gr[i] <= CCPT_GR_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cap_hit[i]) begin
          gr[i] <= free_run_count;
        end else if (wr_gr[i]) begin
          gr[i] <= hwdata_i[CNT_W-1:0];
        end
      end
      if (buf_a && cmp_hit[0]) begin
        gr[0] <= gr[2];
      end
      if (buf_a && cap_hit[0]) begin
        gr[2] <= gr[0];
      end
      if (buf_b && cmp_hit[1]) begin
        gr[1] <= gr[3];
      end
      if (buf_b && cap_hit[1]) begin
        gr[3] <= gr[1];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status flags: set wins over clear; clear needs a prior read of one
  // ----------------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] read_armed;
  logic       rd_status;

  assign flag_set  = {ovf_evt, 3'h0, cmp_hit | cap_hit};
  assign rd_status = ph_rd && (ph_addr == CCPT_OFS_STATUS);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_status_reg <= '0;
      read_armed       <= '0;
    end else begin
      if (rd_status) begin
        read_armed <= hrdata_o[7:0];  // Only bits the read returned
      end else if (wr_status) begin
        read_armed <= '0;
      end
      timer_status_reg <= flag_set | (timer_status_reg &
                          ~(wr_status ? (read_armed & ~hwdata_i[7:0]) : 8'h00));
    end
  end

  assign irq_o = |(timer_status_reg & timer_irq_enable_reg);

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_mode_reg       <= '0;
      timer_control_reg    <= '0;
      timer_irq_enable_reg <= '0;
      io_control_ab        <= '0;
      io_control_cd        <= '0;
    end else begin
      if (wr_mode)  timer_mode_reg       <= hwdata_i[7:0];
      if (wr_ctrl)  timer_control_reg    <= hwdata_i[7:0];
      if (wr_irqen) timer_irq_enable_reg <= hwdata_i[7:0];
      if (wr_ab)    io_control_ab        <= hwdata_i[7:0];
      if (wr_cd)    io_control_cd        <= hwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Pin outputs; a control write loads the initial levels and wins
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_level <= '0;
    end else if (wr_ctrl) begin
      pin_level <= hwdata_i[CCPT_CTRL_LVL +: 4];
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pwm_on[i]) begin
          // Equal duty and period: no change at all
          if (gr[i] != gr[0]) begin
            if (cmp_hit[0]) begin
              pin_level[i] <= timer_control_reg[CCPT_CTRL_LVL + i];
            end else if (cmp_hit[i]) begin
              pin_level[i] <= !timer_control_reg[CCPT_CTRL_LVL + i];
            end
          end
        end else if (cmp_hit[i]) begin
          unique case (io_cfg[i].sel)
            CCPT_OUT_NONE: pin_level[i] <= pin_level[i];
            CCPT_OUT_LOW:  pin_level[i] <= 1'b0;
            CCPT_OUT_HIGH: pin_level[i] <= 1'b1;
            CCPT_OUT_TOG:  pin_level[i] <= !pin_level[i];
          endcase
        end
      end
    end
  end

  // Pins drive only in PWM use, or in compare use with an output selected
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pins.dout[i] = pin_level[i];
      pins.oe_n[i] = !(pwm_on[i] ||
                       (is_cmp[i] && (io_cfg[i].sel != CCPT_OUT_NONE)));
    end
  end

  assign timer_pin_o      = pins.dout;
  assign timer_pin_oe_n_o = pins.oe_n;

  // ----------------------------------------------------------------------
  // Read data, registered in the data phase
  // ----------------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    unique case (haddr_i[CCPT_ADDR_W-1:0])
      CCPT_OFS_COUNT:  next_rdata[CNT_W-1:0] = free_run_count;
      CCPT_OFS_GRA:    next_rdata[CNT_W-1:0] = gr[0];
      CCPT_OFS_GRB:    next_rdata[CNT_W-1:0] = gr[1];
      CCPT_OFS_GRC:    next_rdata[CNT_W-1:0] = gr[2];
      CCPT_OFS_GRD:    next_rdata[CNT_W-1:0] = gr[3];
      CCPT_OFS_MODE:   next_rdata[7:0] = timer_mode_reg;
      CCPT_OFS_CTRL:   next_rdata[7:0] = timer_control_reg;
      CCPT_OFS_IRQEN:  next_rdata[7:0] = timer_irq_enable_reg;
      CCPT_OFS_STATUS: next_rdata[7:0] = timer_status_reg;
      CCPT_OFS_IOAB:   next_rdata[7:0] = io_control_ab;
      CCPT_OFS_IOCD:   next_rdata[7:0] = io_control_cd;
      default:         next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hrdata_o <= '0;
    end else if (take && !hwrite_i) begin
      hrdata_o <= next_rdata;
    end
  end

endmodule : ccpt_timer

`default_nettype wire

// ### verif/ccpt_checker.sv
// Checker on the timer ports: bus answer, read data, reset state, pin levels.
// Assumes ccpt_timer as the bind target and a single clock domain.
`default_nettype none
module ccpt_checker
  import ccpt_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [3:0]  timer_pin_o,
  input wire logic [3:0]  timer_pin_oe_n_o,
  input wire logic        irq_o
);
  // --------
  // Helpers
  // --------
  logic take_a;
  logic rd_a;
  logic wr_a;
  // Address phases taken; writes land one edge later, and only whole words land
  assign take_a = hsel_i && hready_i && htrans_i == CCPT_HTRANS_NONSEQ;
  assign rd_a   = take_a && !hwrite_i;
  assign wr_a   = take_a && hwrite_i && hsize_i == CCPT_HSIZE_WORD;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_ctrl_wr;
    wr_a && haddr_i[7:0] == CCPT_OFS_CTRL;
  endsequence
  // Level bits load the pins at the edge that ends the data phase
  property p_level;
    logic [3:0] v;
    s_ctrl_wr ##1 (1'b1, v = hwdata_i[3:0]) |=> timer_pin_o == v;
  endproperty
  chk_ctrl_level: assert property (p_level)
    else $error("pin levels differ from written level bits");
  chk_zero_wait: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not zero-wait OKAY");
  chk_rdata_hold: assert property (!$past(rd_a) |-> $stable(hrdata_o))
    else $error("read data moved without a read");
  chk_rd_upper: assert property (rd_a |=> hrdata_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_unmapped_rd: assert property (
      rd_a && haddr_i[7:0] > CCPT_OFS_IOCD |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_out: assert property ($rose(reset_n_i) |-> !irq_o && timer_pin_o == 4'h0)
    else $error("outputs not idle after reset");
  chk_oe_by_write: assert property ($changed(timer_pin_oe_n_o) |-> $past(wr_a, 2))
    else $error("pin enable moved without a write");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(wr_a, 2))
    else $error("interrupt dropped without a write");
endmodule // ccpt_checker

bind ccpt_timer ccpt_checker u_chk (
  .clk_sys_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
  .hsize_i, .hrdata_o, .hreadyout_o, .hresp_o, .timer_pin_o, .timer_pin_oe_n_o, .irq_o
);
`default_nettype wire

// ### verif/ccpt_pin_model.sv
// Far side of the timer pins: capture sources and the external count clock.
// Assumes each timer pin is split into in, out and active-low enable.
`default_nettype none
module ccpt_pin_model (
  input  wire logic       clk_sys_i,
  input  wire logic [3:0] drv_i,
  input  wire logic [3:0] dut_pin_i,
  input  wire logic [3:0] dut_oe_n_i,
  input  wire logic       ext_go_i,
  output logic      [3:0] pin_lvl_o,
  output logic            ext_clk_o
);
  logic [1:0] ph;
  // Wire level: the timer wins where it drives, else our source level
  assign pin_lvl_o = (dut_oe_n_i & drv_i) | (~dut_oe_n_i & dut_pin_i);
  // Two cycles high, two low; stands low when not asked to run
  always_ff @(posedge clk_sys_i) begin
    ph <= ext_go_i ? ph + 2'h1 : 2'h0;
  end
  assign ext_clk_o = ph[1];
endmodule // ccpt_pin_model
`default_nettype wire

// ### verif/ccpt_timer_tb.sv
// Self-checking bench for the capture/compare/PWM timer over AHB-Lite.
// Assumes ccpt_timer, the bound checker and the pin-side partner model.
`default_nettype none
module ccpt_timer_tb import ccpt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic        hsel   = 1'b0;
  logic        hwrite = 1'b0;
  logic        ext_go = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize  = 3'h2;
  logic [3:0]  drv    = 4'h0;
  logic [31:0] hrdata, rd;
  logic [3:0]  pin_i, pin_o, oe_n;
  logic        hrdy, hresp, ext_clk, irq, lv;
  int          n_fail = 0;
  int          checked = 0;
  int          k, t;
  int          gr[4];  // Model of general registers A..D
  // 100 MHz system clock
  always #5 clk = ~clk;
  ccpt_timer DUT (.clk_sys_i(clk), .reset_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
    .timer_pin_i(pin_i), .timer_pin_o(pin_o), .timer_pin_oe_n_o(oe_n),
    .ext_clk_i(ext_clk), .irq_o(irq));
  ccpt_pin_model PM (.clk_sys_i(clk), .drv_i(drv), .dut_pin_i(pin_o), .dut_oe_n_i(oe_n),
    .ext_go_i(ext_go), .pin_lvl_o(pin_i), .ext_clk_o(ext_clk));
  // --------
  // Tasks
  // --------
  task automatic summarize();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait for the slave's ready; a hang ends the run
  task automatic wait_rdy();
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (hrdy === 1'b1) return;
    end
    chk("hready", hrdy, 1'b1);
    summarize();
  endtask
  task automatic wait_irq(input logic v);
    for (int i = 0; i < 200 && irq !== v; i++) @(posedge clk);
    if (irq !== v) begin
      chk("irq_wait", irq, v);
      summarize();
    end
  endtask
  // One single transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= CCPT_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sz;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
    // Select stays up between transfers; an IDLE htrans ends each one
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, CCPT_HSIZE_WORD, d, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(a, 1'b0, CCPT_HSIZE_WORD, 32'h0, rd);
    chk(nm, rd, e);
  endtask
  // Read status to arm the set bits, then write zero to clear them
  task automatic clr();
    bus(CCPT_OFS_STATUS, 1'b0, CCPT_HSIZE_WORD, 32'h0, rd);
    wr(CCPT_OFS_STATUS, 32'h0);
  endtask
  task automatic reset_vals();
    for (k = 0; k < 4; k++) gr[k] = 32'hFFFF;
    rdc(CCPT_OFS_COUNT, 32'h0, "count_rst");
    for (k = 0; k < 4; k++) rdc(CCPT_OFS_GRA + 8'(4 * k), gr[k], "gr_rst");
    rdc(8'h2C, 32'h0, "unmapped");
  endtask
  // --------
  // Scenarios
  // --------
  initial begin
    void'($urandom(32'h9997C3C4));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reset_vals();
    // Random words in every general register; a byte write must be dropped
    for (k = 0; k < 4; k++) begin
      gr[k] = $urandom & 32'hFFFF;
      wr(CCPT_OFS_GRA + 8'(4 * k), gr[k]);
      bus(CCPT_OFS_GRA + 8'(4 * k), 1'b1, 3'h0, ~gr[k], rd);
      rdc(CCPT_OFS_GRA + 8'(4 * k), gr[k], "gr_rw");
    end
    t = $urandom & 32'hFFFF;
    wr(CCPT_OFS_COUNT, t);
    repeat (5) @(posedge clk);
    rdc(CCPT_OFS_COUNT, t, "count_stopped");
    // Rollover raises overflow; a write without a prior read keeps it
    wr(CCPT_OFS_COUNT, 32'hFFF0);
    wr(CCPT_OFS_IRQEN, 32'h80);
    wr(CCPT_OFS_MODE, 32'h1);
    wait_irq(1'b1);
    wr(CCPT_OFS_MODE, 32'h0);
    wr(CCPT_OFS_STATUS, 32'h0);
    @(posedge clk);
    chk("irq_kept", irq, 1'b1);
    clr();
    chk("ovf_flag", rd[7], 1'b1);
    wait_irq(1'b0);
    // Output selections on A with clearing at match A (period 10)
    wr(CCPT_OFS_COUNT, 32'h0);
    wr(CCPT_OFS_GRA, 32'h9);
    gr[0] = 9;
    for (k = 0; k < 3; k++) begin
      wr(CCPT_OFS_CTRL, k == 2 ? 32'h80 : 32'h81);
      wr(CCPT_OFS_IOAB, k);
      wr(CCPT_OFS_MODE, 32'h1);
      repeat (25) @(posedge clk);
      chk("pin_a_out", pin_o[0], k != 1);
      wr(CCPT_OFS_MODE, 32'h0);
    end
    wr(CCPT_OFS_IOAB, 32'h3);
    wr(CCPT_OFS_IRQEN, 32'h1);
    wr(CCPT_OFS_MODE, 32'h1);
    repeat (2) begin
      lv = pin_o[0];
      for (k = 0; k < 30 && pin_o[0] === lv; k++) @(posedge clk);
    end
    chk("toggle_gap", k, 10);
    chk("irq_match_a", irq, 1'b1);
    wr(CCPT_OFS_MODE, 32'h2);
    wr(CCPT_OFS_IOAB, 32'h0);
    clr();
    // Buffered capture on A for every edge selection and both edges
    for (k = 0; k < 8; k++) begin
      wr(CCPT_OFS_IOAB, 32'h4 | (k >> 1));
      t = $urandom & 32'hFFFF;
      wr(CCPT_OFS_COUNT, t);
      drv[0] <= ~k[0];
      repeat (8) @(posedge clk);
      if ((k >> 1) > 1 || (k & 1) == (k >> 1)) begin
        gr[2] = gr[0];
        gr[0] = t;
      end
      rdc(CCPT_OFS_GRA, gr[0], "cap_a");
      rdc(CCPT_OFS_GRC, gr[2], "buf_c");
    end
    // PWM on B buffered by D: duty 9 is replaced by 4 at the first match B,
    // so steady state gives 10 of 40; duty equal to period holds the pin
    wr(CCPT_OFS_IOAB, 32'h0);
    wr(CCPT_OFS_GRA, 32'h13);
    for (k = 0; k < 2; k++) begin
      wr(CCPT_OFS_MODE, 32'h0);
      wr(CCPT_OFS_COUNT, 32'h0);
      wr(CCPT_OFS_GRB, k ? 32'h13 : 32'h9);
      wr(CCPT_OFS_GRD, k ? 32'h13 : 32'h4);
      wr(CCPT_OFS_CTRL, 32'h2);
      wr(CCPT_OFS_MODE, 32'hD);
      repeat (25) @(posedge clk);
      t = 0;
      repeat (40) begin
        @(posedge clk);
        t += pin_o[1];
      end
      chk("pwm_high", t, k ? 40 : 10);
    end
    // Divide by four: reads 40 edges apart differ by ten; C loads A at match 2
    wr(CCPT_OFS_MODE, 32'h0);
    wr(CCPT_OFS_CTRL, 32'h20);
    wr(CCPT_OFS_COUNT, 32'h0);
    wr(CCPT_OFS_GRA, 32'h2);
    wr(CCPT_OFS_GRC, 32'h30);
    wr(CCPT_OFS_MODE, 32'h3);
    bus(CCPT_OFS_COUNT, 1'b0, CCPT_HSIZE_WORD, 32'h0, rd);
    t = rd;
    repeat (38) @(posedge clk);
    rdc(CCPT_OFS_COUNT, t + 10, "presc_ticks");
    rdc(CCPT_OFS_GRA, 32'h30, "buf_cmp_a");
    // Ten external pulses, each level held two cycles
    wr(CCPT_OFS_MODE, 32'h0);
    wr(CCPT_OFS_CTRL, 32'h70);
    wr(CCPT_OFS_COUNT, 32'h0);
    wr(CCPT_OFS_MODE, 32'h1);
    ext_go <= 1'b1;
    repeat (40) @(posedge clk);
    ext_go <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(CCPT_OFS_COUNT, 32'hA, "ext_ticks");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reset_vals();
    summarize();
  end
endmodule // ccpt_timer_tb
`default_nettype wire
